/* File: logic/vut_pkg.sv */
// Package for the vector upper-state tracker.
// Assumes a single core clock domain; no software-visible registers.
package vut_pkg;
	typedef enum logic [1:0] {
		VUT_CLEAN = 2'h0,
		VUT_DIRTY = 2'h1,
		VUT_SAVED = 2'h2
	} vut_state_t;

	// Instruction classes presented by issue
	typedef enum logic [2:0] {
		VUT_OP_NONE = 3'h0,
		VUT_OP_LEGACY = 3'h1,
		VUT_OP_WIDE256 = 3'h2,
		VUT_OP_WIDE128 = 3'h3,
		VUT_OP_ZERO = 3'h4,
		VUT_OP_XSTATE = 3'h5
	} vut_op_t;

	localparam int VUT_STALL_CYC = 8;
	localparam int VUT_REGS = 16;
	localparam int VUT_UPPER_W = 128;
	localparam int VUT_CNT_W = 8;
	localparam int VUT_IDX_W = 4;
endpackage : vut_pkg

/* File: logic/vut_tracker.sv */
// Vector upper-half state tracker with upper-half storage and save area.
// Assumes issue holds op stable while stall is high and that the
// state-save/restore op has already moved the save area in memory.
// Contract
// RULE_01: Reset leaves the tracker clean with every upper half zero.
// RULE_02: A 256-bit wide instruction moves the tracker to modified-unsaved.
// RULE_03: A legacy instruction in modified-unsaved saves all upper halves and moves to saved.
// RULE_04: A wide instruction in saved restores all upper halves and returns to modified-unsaved.
// RULE_05: The zeroing instruction clears all upper halves and goes clean from any state.
// RULE_06: The zeroing instruction completes with no stall.
// RULE_07: A 128-bit wide instruction writes zero to its destination upper half.
// RULE_08: Legacy instructions leave upper halves alone; wide ones write their destination.
// RULE_09: Save or restore penalty applies only when leaving or re-entering modified-unsaved.
// RULE_10: In clean state both instruction kinds run without penalty.
// RULE_11: After a state-save or state-restore instruction the tracker records the saved state; from clean the code leaves it clean.
// RULE_12: A three-operand wide instruction writes only its destination.
// RULE_13: Save and restore stall issue a set number of cycles and pulse done before proceeding.
`timescale 1ns/1ps
`default_nettype none
module vut_tracker
	import vut_pkg::*;
#(
	parameter int STALL_CYC = VUT_STALL_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Issue side
	input wire logic op_valid,
	input wire vut_op_t op_kind,
	input wire logic [VUT_IDX_W-1:0] dst_idx,
	input wire logic [VUT_UPPER_W-1:0] dst_upper,
	// Upper-half read port
	input wire logic [VUT_IDX_W-1:0] rd_idx,
	output logic [VUT_UPPER_W-1:0] rd_upper,
	// Status to pipeline
	output vut_state_t state,
	output logic stall,
	output logic xfer_done,
	output logic penalty
);
	typedef struct packed {
		vut_state_t st;
		logic busy;
		logic restore;
		logic [VUT_CNT_W-1:0] cnt;
		logic done;
		logic pen;
		logic [VUT_UPPER_W-1:0] rd;
		logic [VUT_REGS-1:0][VUT_UPPER_W-1:0] up;
		logic [VUT_REGS-1:0][VUT_UPPER_W-1:0] area;
	} vut_regs_t;

	vut_regs_t r_q, r_d;

	function automatic logic is_wide(input vut_op_t k);
		is_wide = (k == VUT_OP_WIDE256) || (k == VUT_OP_WIDE128);
	endfunction : is_wide

	localparam logic [VUT_CNT_W-1:0] STALL_LAST = VUT_CNT_W'(STALL_CYC - 1);

	always_comb begin
		r_d = r_q;
		r_d.done = 1'b0;
		r_d.pen = 1'b0;
		if (r_q.busy) begin
			if (r_q.cnt == STALL_LAST) begin
				// Penalty ends; triggering op is not replayed here, issue must present it again
				r_d.busy = 1'b0;
				r_d.done = 1'b1; // RULE_13
				r_d.cnt = '0;
				if (r_q.restore) begin
					r_d.up = r_q.area; // RULE_04
					r_d.st = VUT_DIRTY;
				end else begin
					r_d.area = r_q.up; // RULE_03
					r_d.st = VUT_SAVED;
				end
			end else begin
				r_d.cnt = r_q.cnt + 1'b1; // RULE_13
			end
		end else if (op_valid) begin
			case (op_kind)
				VUT_OP_ZERO: begin
					// Zero latency: no busy phase
					r_d.up = '0; // RULE_05 RULE_06
					r_d.st = VUT_CLEAN;
				end
				VUT_OP_LEGACY: begin
					// Uppers untouched; save only when leaving dirty
					if (r_q.st == VUT_DIRTY) begin // RULE_08 RULE_09 RULE_10
						r_d.busy = 1'b1;
						r_d.restore = 1'b0;
						r_d.pen = 1'b1;
					end
				end
				VUT_OP_WIDE256,
				VUT_OP_WIDE128: begin
					if (r_q.st == VUT_SAVED) begin // RULE_04 RULE_09
						r_d.busy = 1'b1;
						r_d.restore = 1'b1;
						r_d.pen = 1'b1;
					end else begin
						// Only destination written; sources untouched
						r_d.up[dst_idx] = (op_kind == VUT_OP_WIDE128) ? '0 : dst_upper; // RULE_07 RULE_12
						r_d.st = VUT_DIRTY; // RULE_02 RULE_08
					end
				end
				VUT_OP_XSTATE: begin
					r_d.area = r_q.up; // RULE_11
					if (r_q.st != VUT_CLEAN) begin
						r_d.st = VUT_SAVED;
					end
				end
				default: begin
				end
			endcase
		end
		r_d.rd = r_d.up[rd_idx];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_q <= '0; // RULE_01
		end else begin
			r_q <= r_d;
		end
	end

	assign rd_upper = r_q.rd;
	assign state = r_q.st;
	assign stall = r_q.busy;
	assign xfer_done = r_q.done;
	assign penalty = r_q.pen;

	// Steps of a save, restore, zeroing or held stall, shared by the checks below
	sequence legacy_on_dirty_s;
		op_valid && !stall && op_kind == VUT_OP_LEGACY && state == VUT_DIRTY;
	endsequence
	sequence wide_on_saved_s;
		op_valid && !stall && is_wide(op_kind) && state == VUT_SAVED;
	endsequence
	sequence zero_taken_s;
		op_valid && !stall && op_kind == VUT_OP_ZERO;
	endsequence
	sequence save_done_s;
		xfer_done && state == VUT_SAVED;
	endsequence
	sequence restore_done_s;
		xfer_done && state == VUT_DIRTY;
	endsequence
	sequence stall_held_s;
		stall ##1 stall;
	endsequence

	reset_clean_a: assert property (@(posedge clk) // RULE_01
		$rose(!rst) |-> state == VUT_CLEAN)
		else $error("not clean after reset");
	reset_quiet_a: assert property (@(posedge clk) // RULE_01
		$rose(!rst) |-> !stall && !xfer_done && !penalty && rd_upper == '0)
		else $error("outputs not idle after reset");
	wide_dirty_a: assert property (@(posedge clk) disable iff (rst) // RULE_02
		op_valid && !stall && op_kind == VUT_OP_WIDE256 && state != VUT_SAVED
		|=> state == VUT_DIRTY)
		else $error("wide op left tracker not dirty");
	save_seq_a: assert property (@(posedge clk) disable iff (rst) // RULE_03
		legacy_on_dirty_s |=> stall [*8] ##1 (xfer_done && state == VUT_SAVED))
		else $error("save sequence wrong");
	save_area_a: assert property (@(posedge clk) disable iff (rst) // RULE_03
		save_done_s |-> r_q.area == $past(r_q.up) && $stable(r_q.up))
		else $error("save area does not hold the uppers");
	restore_seq_a: assert property (@(posedge clk) disable iff (rst) // RULE_04
		wide_on_saved_s |=> stall [*8] ##1 (xfer_done && state == VUT_DIRTY))
		else $error("restore sequence wrong");
	restore_area_a: assert property (@(posedge clk) disable iff (rst) // RULE_04
		restore_done_s |-> r_q.up == $past(r_q.area))
		else $error("restore did not bring back the uppers");
	zero_clean_a: assert property (@(posedge clk) disable iff (rst) // RULE_05
		op_valid && !stall && op_kind == VUT_OP_ZERO
		|=> state == VUT_CLEAN && !stall && rd_upper == '0)
		else $error("zeroing failed or stalled");
	zero_all_a: assert property (@(posedge clk) disable iff (rst) // RULE_05
		zero_taken_s |=> r_q.up == '0)
		else $error("zeroing left an upper half set");
	zero_free_a: assert property (@(posedge clk) disable iff (rst) // RULE_06
		op_valid && !stall && op_kind == VUT_OP_ZERO |=> !penalty)
		else $error("zeroing charged a penalty");
	w128_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE_07
		op_valid && !stall && op_kind == VUT_OP_WIDE128 && state != VUT_SAVED
		&& rd_idx == dst_idx |=> rd_upper == '0)
		else $error("128-bit op kept upper");
	legacy_keep_a: assert property (@(posedge clk) disable iff (rst) // RULE_08
		op_valid && !stall && op_kind == VUT_OP_LEGACY && state != VUT_DIRTY
		&& $stable(rd_idx) |=> $stable(rd_upper))
		else $error("legacy op changed upper");
	w256_write_a: assert property (@(posedge clk) disable iff (rst) // RULE_08
		op_valid && !stall && op_kind == VUT_OP_WIDE256 && state != VUT_SAVED
		|=> r_q.up[$past(dst_idx)] == $past(dst_upper))
		else $error("wide op did not write its destination");
	clean_free_a: assert property (@(posedge clk) disable iff (rst) // RULE_10
		op_valid && !stall && state == VUT_CLEAN |=> !penalty && !stall)
		else $error("penalty in clean state");
	pen_dirty_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
		penalty |-> $past(state) != VUT_CLEAN)
		else $error("penalty not tied to dirty");
	pen_start_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
		penalty |-> stall && !$past(stall))
		else $error("penalty without a fresh stall");
	xstate_saved_a: assert property (@(posedge clk) disable iff (rst) // RULE_11
		op_valid && !stall && op_kind == VUT_OP_XSTATE && state != VUT_CLEAN
		|=> state == VUT_SAVED)
		else $error("state-save did not mark saved");
	xstate_clean_a: assert property (@(posedge clk) disable iff (rst) // RULE_11
		op_valid && !stall && op_kind == VUT_OP_XSTATE && state == VUT_CLEAN
		|=> state == VUT_CLEAN && !stall)
		else $error("state-save left clean state");
	w_only_dst_a: assert property (@(posedge clk) disable iff (rst) // RULE_12
		op_valid && !stall && is_wide(op_kind) && state != VUT_SAVED
		&& rd_idx != dst_idx && $stable(rd_idx) |=> $stable(rd_upper))
		else $error("wide op touched a source upper");
	done_after_a: assert property (@(posedge clk) disable iff (rst) // RULE_13
		xfer_done |-> !stall && $past(stall))
		else $error("done without a finished stall");
	done_pulse_a: assert property (@(posedge clk) disable iff (rst) // RULE_13
		xfer_done |=> !xfer_done)
		else $error("done held longer than one cycle");
	busy_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE_13
		stall_held_s |-> $stable(state))
		else $error("state moved during a stall");
endmodule : vut_tracker
`default_nettype wire

/* File: verif/vut_issue_model.sv */
// Issue-stage model standing in front of the tracker.
// Assumes the tracker's registered stall level and one core clock.
`timescale 1ns/1ps
`default_nettype none
module vut_issue_model
	import vut_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Request and stall
	input wire logic in_valid,
	input wire vut_op_t in_kind,
	input wire logic stall,
	// To tracker
	output logic op_valid,
	output vut_op_t op_kind
);
	// Held while stalled, so a refused op stays presented
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op_valid <= 1'b0;
			op_kind <= VUT_OP_NONE;
		end else if (!stall) begin
			op_valid <= in_valid;
			op_kind <= in_kind;
		end
	end
endmodule : vut_issue_model
`default_nettype wire

/* File: verif/test_vector_upper_state_tracker.sv */
// Bench for the tracker: op table through the issue model, then a mid-run reset.
// Assumes STALL_CYC kept at 8 and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_vector_upper_state_tracker;
	import vut_pkg::*;
	typedef struct packed {
		vut_op_t kind;
		logic [3:0] dst;
		logic [127:0] data;
		logic [3:0] rd;
		logic [127:0] up;
		vut_state_t st;
		logic [1:0] stl;
	} vut_row_t;
	logic clk, rst, in_valid, op_valid, stall, xfer_done, penalty;
	vut_op_t in_kind, op_kind;
	logic [3:0] dst_idx, rd_idx;
	logic [127:0] dst_upper, rd_upper;
	vut_state_t state;
	int mismatches, n_checks, cyc, cnt, pen, dn;
	vut_row_t rows [18];
	vut_issue_model u_iss (.clk(clk), .rst(rst), .in_valid(in_valid), .in_kind(in_kind),
		.stall(stall), .op_valid(op_valid), .op_kind(op_kind));
	vut_tracker #(.STALL_CYC(8)) u_dut (.clk(clk), .rst(rst), .op_valid(op_valid),
		.op_kind(op_kind), .dst_idx(dst_idx), .dst_upper(dst_upper), .rd_idx(rd_idx),
		.rd_upper(rd_upper), .state(state), .stall(stall), .xfer_done(xfer_done), .penalty(penalty));
	task check(input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// Stall of 2 in a row means its length is not judged
	task run(input vut_row_t r);
		@(posedge clk);
		in_valid <= 1'b1;
		in_kind <= r.kind;
		dst_idx <= r.dst;
		dst_upper <= r.data;
		rd_idx <= r.rd;
		@(posedge clk);
		in_valid <= 1'b0;
		cnt = 0;
		pen = 0;
		dn = 0;
		repeat (14) begin
			@(posedge clk);
			#1;
			cnt += stall;
			pen += penalty;
			dn += xfer_done;
		end
		check(state, r.st);
		check(rd_upper, r.up);
		if (r.stl != 2'h2) begin
			check(cnt, 8 * r.stl);
			check(pen, r.stl);
			check(dn, r.stl);
		end
	endtask : run
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		rst = 1'b1;
		in_valid = 1'b0;
		in_kind = VUT_OP_NONE;
		dst_idx = 4'h0;
		dst_upper = 128'h0;
		rd_idx = 4'h0;
		rows = '{'{VUT_OP_LEGACY, 4'h0, 128'h0, 4'h3, 128'h0, VUT_CLEAN, 2'h0},
			'{VUT_OP_WIDE256, 4'h3, 128'hA1, 4'h3, 128'hA1, VUT_DIRTY, 2'h0},
			'{VUT_OP_WIDE256, 4'h5, 128'hB2, 4'h3, 128'hA1, VUT_DIRTY, 2'h0},
			'{VUT_OP_WIDE128, 4'h5, 128'hC3, 4'h5, 128'h0, VUT_DIRTY, 2'h0},
			'{VUT_OP_LEGACY, 4'h0, 128'h0, 4'h3, 128'hA1, VUT_SAVED, 2'h1},
			'{VUT_OP_LEGACY, 4'h0, 128'h0, 4'h3, 128'hA1, VUT_SAVED, 2'h0},
			'{VUT_OP_WIDE256, 4'h3, 128'hD4, 4'h3, 128'hA1, VUT_DIRTY, 2'h1},
			'{VUT_OP_WIDE256, 4'h3, 128'hD4, 4'h3, 128'hD4, VUT_DIRTY, 2'h0},
			'{VUT_OP_XSTATE, 4'h0, 128'h0, 4'h3, 128'hD4, VUT_SAVED, 2'h0},
			'{VUT_OP_ZERO, 4'h0, 128'h0, 4'h3, 128'h0, VUT_CLEAN, 2'h0},
			'{VUT_OP_WIDE256, 4'h2, 128'hE5, 4'h2, 128'hE5, VUT_DIRTY, 2'h0},
			'{VUT_OP_LEGACY, 4'h0, 128'h0, 4'h2, 128'hE5, VUT_SAVED, 2'h1},
			'{VUT_OP_WIDE128, 4'h2, 128'hC3, 4'h2, 128'hE5, VUT_DIRTY, 2'h1},
			'{VUT_OP_WIDE256, 4'h6, 128'hF6, 4'h6, 128'hF6, VUT_DIRTY, 2'h0},
			'{VUT_OP_ZERO, 4'h0, 128'h0, 4'h6, 128'h0, VUT_CLEAN, 2'h0},
			'{VUT_OP_XSTATE, 4'h0, 128'h0, 4'h6, 128'h0, VUT_CLEAN, 2'h0},
			'{VUT_OP_WIDE128, 4'h4, 128'h77, 4'h4, 128'h0, VUT_DIRTY, 2'h0},
			'{VUT_OP_NONE, 4'h6, 128'h99, 4'h6, 128'h0, VUT_DIRTY, 2'h0}};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		check(state, VUT_CLEAN);
		check(rd_upper, 128'h0);
		foreach (rows[i]) run(rows[i]);
		// Reset in mid-save must drop the stall at once
		@(posedge clk);
		in_valid <= 1'b1;
		in_kind <= VUT_OP_LEGACY;
		@(posedge clk);
		in_valid <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		check(stall, 1'b1);
		rst <= 1'b1;
		#1;
		check(stall, 1'b0);
		check(state, VUT_CLEAN);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(state, VUT_CLEAN);
		check(rd_upper, 128'h0);
		check(xfer_done, 1'b0);
		check(penalty, 1'b0);
		run(rows[1]);
		end_of_test();
	end
endmodule : test_vector_upper_state_tracker
`default_nettype wire
